// ===== sim/sfrd_host_model.sv
// Host model that drives select, serial clock and data on the first line.
`timescale 1ns/1ns
module sfrd_host_model (
  // Pins
  output logic cs_n,
  output logic sclk,
  output wire [3:0] dq_in,
  input wire [3:0] dq_out,
  input wire [3:0] dq_oe
);
  // ----
  // Pin sequencing
  // ----
  logic [3:0] drv;
  logic [7:0] rx [0:3];
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & drv);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    drv = 4'h0;
  end
  // Released lines toggle so that a stale level never reads as data.
  task bit1(input logic b, output logic r);
    sclk = 1'b0;
    drv[0] = b;
    drv[3:1] = ~drv[3:1];
    #40 sclk = 1'b1;
    #39 r = dq_in[1];
    #1;
  endtask
  task run(input logic [7:0] op, input logic [31:0] a, input int nab, nd, nbits);
    logic r;
    cs_n = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--) bit1(op[i], r);
    for (int i = nab * 8 - 1; i >= 0; i--) bit1(a[i], r);
    for (int i = 0; i < nd; i++) bit1(~drv[0], r);
    for (int i = 0; i < nbits; i++) begin
      bit1(~drv[0], r);
      rx[i / 8] = {rx[i / 8][6:0], r};
    end
    cs_n = 1'b1;
    #80;
  endtask
endmodule

// ===== sim/sfrd_read_front_end_properties.sv
// Concurrent checks on the ports of the read-command front end.
`timescale 1ns/1ns
module sfrd_read_front_end_checker (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Observed ports
  input wire cs_n,
  input wire [3:0] serial_data_lines_oe,
  input wire fetch_req_valid,
  input wire fetch_req_ready,
  input wire [31:0] fetch_req_addr,
  input wire [1:0] fetch_req_space,
  input wire addr4_cmd_pulse,
  input wire addr4_cmd_enter,
  input wire addr4_mode,
  input wire cmd_active
);
  // ----
  // Port relations
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  oe_idle_a: assert property (cs_n [*8] |-> serial_data_lines_oe == 4'h0)
    else $error("Data lines driven while deselected");
  active_idle_a: assert property (cs_n [*8] |-> !cmd_active)
    else $error("Command still active while deselected");
  req_hold_a: assert property (fetch_req_valid && !fetch_req_ready && !cs_n |=>
    fetch_req_valid && $stable(fetch_req_addr)) else $error("Fetch request dropped");
  one_flight_a: assert property (fetch_req_valid && fetch_req_ready |=> !fetch_req_valid)
    else $error("Second fetch request while one in flight");
  space_code_a: assert property (fetch_req_valid |-> fetch_req_space != 2'h0)
    else $error("Fetch request without a space");
  disc_wrap_a: assert property (fetch_req_valid && fetch_req_space == 2'h2 |->
    fetch_req_addr[31:11] == 21'h0_0000) else $error("Table address beyond its end");
  mode_latch_a: assert property (addr4_cmd_pulse |=> addr4_mode == $past(addr4_cmd_enter))
    else $error("Address mode did not follow the command");
  oe_shape_a: assert property (serial_data_lines_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("Illegal line enable pattern");
endmodule
bind sfrd_read_front_end sfrd_read_front_end_checker chk_i (.clock, .arst_n, .cs_n,
  .serial_data_lines_oe, .fetch_req_valid, .fetch_req_ready, .fetch_req_addr,
  .fetch_req_space, .addr4_cmd_pulse, .addr4_cmd_enter, .addr4_mode, .cmd_active);

// ===== sim/tb_sfrd_read_front_end.sv
// Self-checking bench for the read-command front end.
`timescale 1ns/1ns
`include "sfrd_defines.vh"
module tb_sfrd_read_front_end;
  logic clock, arst_n, pe_busy, a4p, a4e, rq_rdy, rsp_v, acc, oe_seen, hold_rdy;
  logic [7:0] rsp_d;
  logic [31:0] aq;
  logic [1:0] sq;
  wire cs_n, sclk, rsp_rdy, rq_v, a4m, act;
  wire [3:0] din, dout, doe;
  wire [31:0] rq_a;
  wire [1:0] rq_s;
  int fail_count, n_checks;
  sfrd_host_model h (.cs_n(cs_n), .sclk(sclk), .dq_in(din), .dq_out(dout), .dq_oe(doe));
  sfrd_read_front_end dut (.clock(clock), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
    .serial_data_lines_in(din), .serial_data_lines_out(dout), .serial_data_lines_oe(doe),
    .cfg_protocol(2'h0), .cfg_dtr_enable(1'b0), .cfg_dummy_cycles(4'h0), .cfg_nv_addr4(1'b0),
    .addr4_cmd_pulse(a4p), .addr4_cmd_enter(a4e), .pe_busy(pe_busy),
    .fetch_req_valid(rq_v), .fetch_req_ready(rq_rdy), .fetch_req_addr(rq_a),
    .fetch_req_space(rq_s), .fetch_rsp_valid(rsp_v), .fetch_rsp_ready(rsp_rdy),
    .fetch_rsp_data(rsp_d), .addr4_mode(a4m), .cmd_active(act));
  // ----
  // Memory responder and helpers
  // ----
  function automatic logic [7:0] mem_b(input logic [31:0] a, input logic [1:0] s);
    return a[7:0] ^ a[31:24] ^ {s, 6'h00};
  endfunction
  always @(posedge clock) begin
    acc <= rq_v & rq_rdy;
    aq <= rq_a;
    sq <= rq_s;
    if (doe !== 4'h0) oe_seen <= 1'b1;
  end
  always @(negedge clock) begin
    rq_rdy <= arst_n & ~hold_rdy;
    rsp_v <= acc;
    rsp_d <= mem_b(aq, sq);
  end
  task chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task mode4(input logic e);
    @(negedge clock);
    a4p = 1'b1;
    a4e = e;
    @(negedge clock);
    a4p = 1'b0;
    @(negedge clock);
    chk("a4m", 32'(e), 32'(a4m));
  endtask
  task t_wrap3();
    h.run(`SFRD_OP_RD, 32'h00FF_FFFE, 3, 0, 24);
    chk("rd0", mem_b(32'h00FF_FFFE, 2'h1), h.rx[0]);
    chk("rd2", mem_b(32'h0000_0000, 2'h1), h.rx[2]);
  endtask
  task t_fast();
    h.run(`SFRD_OP_FRD, 32'h0000_1230, 3, 8, 16);
    chk("frd1", mem_b(32'h0000_1231, 2'h1), h.rx[1]);
  endtask
  task t_four();
    h.run(`SFRD_OP_RD4, 32'hFFFF_FFFF, 4, 0, 16);
    chk("rd4a", mem_b(32'hFFFF_FFFF, 2'h1), h.rx[0]);
    chk("rd4b", mem_b(32'h0000_0000, 2'h1), h.rx[1]);
  endtask
  task t_mode();
    mode4(1'b1);
    h.run(`SFRD_OP_RD, 32'h1234_5678, 4, 0, 8);
    chk("rdm4", mem_b(32'h1234_5678, 2'h1), h.rx[0]);
    h.run(`SFRD_OP_DISC, 32'h0000_07FF, 3, 8, 16);
    chk("dsc0", mem_b(32'h0000_07FF, 2'h2), h.rx[0]);
    chk("dsc1", mem_b(32'h0000_0000, 2'h2), h.rx[1]);
    mode4(1'b0);
  endtask
  task t_id();
    oe_seen = 1'b0;
    h.run(`SFRD_OP_ID_B, 32'h0000_0000, 0, 0, 8);
    chk("id_oe", 32'h0000_0001, 32'(oe_seen));
    chk("id_act", 32'h0000_0000, 32'(act));
    pe_busy = 1'b1;
    oe_seen = 1'b0;
    h.run(`SFRD_OP_ID_A, 32'h0000_0000, 0, 0, 8);
    chk("busy_oe", 32'h0000_0000, 32'(oe_seen));
    pe_busy = 1'b0;
  endtask
  task t_abort();
    hold_rdy = 1'b1;
    h.run(`SFRD_OP_RD, 32'h0000_0040, 3, 0, 5);
    chk("ab_oe", 32'h0000_0000, 32'(doe));
    chk("ab_act", 32'h0000_0000, 32'(act));
    hold_rdy = 1'b0;
    @(negedge clock);
  endtask
  task results();
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #500000;
    fail_count++;
    results();
  end
  initial begin
    {arst_n, pe_busy, a4p, a4e, rq_rdy, rsp_v, oe_seen, hold_rdy} = 8'h00;
    rsp_d = 8'h00;
    repeat (8) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_abort();
    t_wrap3();
    t_fast();
    t_four();
    t_mode();
    t_id();
    results();
  end
endmodule

// ===== src/sfrd_defines.vh
// Constants for the serial flash read-command front end.
`ifndef SFRD_DEFINES_VH
`define SFRD_DEFINES_VH
// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define SFRD_OP_ID_A 8'h9E
`define SFRD_OP_ID_B 8'h9F
`define SFRD_OP_ID_MULTI 8'hAF
`define SFRD_OP_DISC 8'h5A
`define SFRD_OP_RD 8'h03
`define SFRD_OP_FRD 8'h0B
`define SFRD_OP_DOFR 8'h3B
`define SFRD_OP_DIOFR 8'hBB
`define SFRD_OP_QOFR 8'h6B
`define SFRD_OP_QIOFR 8'hEB
`define SFRD_OP_DTR_FRD 8'h0D
`define SFRD_OP_DTR_DOFR 8'h3D
`define SFRD_OP_DTR_DIOFR 8'hBD
`define SFRD_OP_DTR_QOFR 8'h6D
`define SFRD_OP_DTR_QIOFR 8'hED
`define SFRD_OP_QWORD 8'hE7
`define SFRD_OP_RD4 8'h13
`define SFRD_OP_FRD4 8'h0C
`define SFRD_OP_DOFR4 8'h3C
`define SFRD_OP_DIOFR4 8'hBC
`define SFRD_OP_QOFR4 8'h6C
`define SFRD_OP_QIOFR4 8'hEC
`define SFRD_OP_DTR_FRD4 8'h0E
`define SFRD_OP_DTR_DIOFR4 8'hBE
`define SFRD_OP_DTR_QIOFR4 8'hEE
// ----------------------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------------------
`define SFRD_ST_IDLE 3'h0
`define SFRD_ST_OPC 3'h1
`define SFRD_ST_ADDR 3'h2
`define SFRD_ST_DUMMY 3'h3
`define SFRD_ST_DATA 3'h4
`define SFRD_ST_IGNORE 3'h5
// ----------------------------------------------------------------------------
// Decode fields
// ----------------------------------------------------------------------------
`define SFRD_AK_NONE 2'h0
`define SFRD_AK_MODE 2'h1
`define SFRD_AK_THREE 2'h2
`define SFRD_AK_FOUR 2'h3
`define SFRD_L1 3'h1
`define SFRD_L2 3'h2
`define SFRD_L4 3'h4
`define SFRD_RT_CFG 1'h0
`define SFRD_RT_DTR 1'h1
`define SFRD_DK_NONE 2'h0
`define SFRD_DK_CFG 2'h1
`define SFRD_DK_EIGHT 2'h2
`define SFRD_DK_FOUR 2'h3
`define SFRD_SP_NONE 2'h0
`define SFRD_SP_MEM 2'h1
`define SFRD_SP_DISC 2'h2
`define SFRD_SP_ID 2'h3
`define SFRD_PROTO_EXT 2'h0
`define SFRD_PROTO_DUAL 2'h1
// ----------------------------------------------------------------------------
// Counts, masks and drive patterns
// ----------------------------------------------------------------------------
`define SFRD_OPC_BITS 6'h08
`define SFRD_ABITS3 6'h18
`define SFRD_ABITS4 6'h20
`define SFRD_BYTE_BITS 4'h8
`define SFRD_DUMMY_DISC 4'h8
`define SFRD_DUMMY_QWORD 4'h4
`define SFRD_DUMMY_FACTORY 4'h8
`define SFRD_MASK_DISC 32'h0000_07FF
`define SFRD_MASK_MEM24 32'h00FF_FFFF
`define SFRD_ADDR_ONE 32'h0000_0001
`define SFRD_FILL_BYTE 8'hFF
`define SFRD_OE_OFF 4'h0
`define SFRD_OE_L1 4'h2
`define SFRD_OE_L2 4'h3
`define SFRD_OE_L4 4'hF
`define SFRD_BUF_FULL 2'h2
`endif

// ===== src/sfrd_pair_buffer.v
// Two-entry valid/ready buffer between the fetch response and the shifter.
`timescale 1ns/1ns
`include "sfrd_defines.vh"
module sfrd_pair_buffer #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  input wire flush,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  reg [1:0] count_next;
  reg in_ready_reg;

  wire push = in_valid & in_ready_reg;
  wire pop = out_valid & out_ready;

  assign in_ready = in_ready_reg;
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem[rd_ptr_reg];

  always @* begin
    count_next = count_reg;
    if (flush) begin
      count_next = 2'h0;
    end else if (push & ~pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop & ~push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      in_ready_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready_reg <= (count_next != `SFRD_BUF_FULL);
      if (flush) begin
        wr_ptr_reg <= 1'b0;
        rd_ptr_reg <= 1'b0;
      end else begin
        if (push) begin
          wr_ptr_reg <= ~wr_ptr_reg;
        end
        if (pop) begin
          rd_ptr_reg <= ~rd_ptr_reg;
        end
      end
    end
  end

endmodule

// ===== src/sfrd_read_front_end.v
// Read-command front end: pin sampling, opcode decode, sequencing and output.
`timescale 1ns/1ns
`include "sfrd_defines.vh"
module sfrd_read_front_end (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Serial pins
  input wire cs_n,
  input wire sclk,
  input wire [3:0] serial_data_lines_in,
  output wire [3:0] serial_data_lines_out,
  output wire [3:0] serial_data_lines_oe,
  // Configuration
  input wire [1:0] cfg_protocol,
  input wire cfg_dtr_enable,
  input wire [3:0] cfg_dummy_cycles,
  input wire cfg_nv_addr4,
  input wire addr4_cmd_pulse,
  input wire addr4_cmd_enter,
  input wire pe_busy,
  // Fetch request
  output wire fetch_req_valid,
  input wire fetch_req_ready,
  output wire [31:0] fetch_req_addr,
  output wire [1:0] fetch_req_space,
  // Fetch response
  input wire fetch_rsp_valid,
  output wire fetch_rsp_ready,
  input wire [7:0] fetch_rsp_data,
  // Status
  output wire addr4_mode,
  output wire cmd_active
);

  // --------------------------------------------------------------------------
  // Pin synchronisers and serial clock edges
  // --------------------------------------------------------------------------
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg sclk_prev_reg;

  wire cs_n_s = sync2_reg[5];
  wire sclk_s = sync2_reg[4];
  wire [3:0] dq_s = sync2_reg[3:0];
  wire rise = sclk_s & ~sclk_prev_reg;
  wire fall = ~sclk_s & sclk_prev_reg;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
      sclk_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {cs_n, sclk, serial_data_lines_in};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[4];
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function [31:0] f_shin;
    input [31:0] v;
    input [2:0] w;
    input [3:0] d;
    begin
      case (w)
        `SFRD_L1: f_shin = {v[30:0], d[0]};
        `SFRD_L2: f_shin = {v[29:0], d[1:0]};
        default: f_shin = {v[27:0], d};
      endcase
    end
  endfunction

  function [3:0] f_drive;
    input [7:0] b;
    input [2:0] w;
    begin
      case (w)
        `SFRD_L1: f_drive = {2'h0, b[7], 1'h0};
        `SFRD_L2: f_drive = {2'h0, b[7:6]};
        default: f_drive = b[7:4];
      endcase
    end
  endfunction

  function [3:0] f_oe;
    input [2:0] w;
    begin
      case (w)
        `SFRD_L1: f_oe = `SFRD_OE_L1;
        `SFRD_L2: f_oe = `SFRD_OE_L2;
        default: f_oe = `SFRD_OE_L4;
      endcase
    end
  endfunction

  function [2:0] f_max;
    input [2:0] a;
    input [2:0] b;
    begin
      f_max = (a > b) ? a : b;
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [2:0] state_reg;
  reg [7:0] opc_reg;
  reg [5:0] cnt_reg;
  reg [31:0] addr_reg;
  reg [5:0] abits_reg;
  reg [2:0] alines_reg;
  reg [2:0] dlines_reg;
  reg dtr_reg;
  reg qword_reg;
  reg [5:0] dummy_reg;
  reg [1:0] space_reg;
  reg [7:0] shift_reg;
  reg [3:0] left_reg;
  reg go_reg;
  reg [3:0] dq_out_reg;
  reg [3:0] dq_oe_reg;
  reg active_reg;
  reg addr4_reg;
  reg init_reg;
  reg [31:0] faddr_reg;
  reg [1:0] fspace_reg;
  reg fwide_reg;
  reg fon_reg;
  reg req_valid_reg;
  reg inflight_reg;
  reg stale_reg;

  wire buf_in_ready;
  wire buf_valid;
  wire [7:0] buf_data;

  // Opcode lines follow the protocol.
  wire [2:0] pl = (cfg_protocol == `SFRD_PROTO_EXT) ? `SFRD_L1 :
                  (cfg_protocol == `SFRD_PROTO_DUAL) ? `SFRD_L2 : `SFRD_L4;
  wire op_edge = rise | (cfg_dtr_enable & fall);
  wire in_edge = rise | (dtr_reg & fall);
  wire out_edge = fall | (dtr_reg & rise);
  wire [31:0] opc_wide = f_shin({24'h00_0000, opc_reg}, pl, dq_s);
  wire [7:0] opc_next = opc_wide[7:0];
  wire [31:0] addr_next = f_shin(addr_reg, alines_reg, dq_s);
  wire [5:0] opc_cnt = cnt_reg + {3'h0, pl};
  wire [5:0] addr_cnt = cnt_reg + {3'h0, alines_reg};
  wire [7:0] next_byte = buf_valid ? buf_data : `SFRD_FILL_BYTE;
  wire pop = (state_reg == `SFRD_ST_DATA) & ~cs_n_s & out_edge & (left_reg == 4'h0);

  // --------------------------------------------------------------------------
  // Opcode decode
  // --------------------------------------------------------------------------
  reg [12:0] dc;
  reg [5:0] dc_dummy;
  wire [1:0] dc_ak = dc[12:11];
  wire [2:0] dc_al = dc[10:8];
  wire [2:0] dc_dl = dc[7:5];
  wire dc_rt = dc[4];
  wire [1:0] dc_dk = dc[3:2];
  wire [1:0] dc_sp = dc[1:0];
  wire eff_dtr = dc_rt | cfg_dtr_enable;
  wire dc_qword = (dc_dk == `SFRD_DK_FOUR);
  wire dc_wide = (dc_ak == `SFRD_AK_FOUR) | ((dc_ak == `SFRD_AK_MODE) & addr4_reg);
  wire accept = (dc_sp != `SFRD_SP_NONE) &
                ~((dc_sp == `SFRD_SP_ID) & pe_busy) &
                ~(dc_qword & (eff_dtr | (cfg_protocol == `SFRD_PROTO_DUAL)));

  always @* begin
    case (opc_next)
      `SFRD_OP_ID_A, `SFRD_OP_ID_B, `SFRD_OP_ID_MULTI:
        dc = {`SFRD_AK_NONE, `SFRD_L1, `SFRD_L1, `SFRD_RT_CFG, `SFRD_DK_NONE, `SFRD_SP_ID};
      `SFRD_OP_DISC:
        dc = {`SFRD_AK_THREE, `SFRD_L1, `SFRD_L1, `SFRD_RT_CFG, `SFRD_DK_EIGHT, `SFRD_SP_DISC};
      `SFRD_OP_RD: dc = {`SFRD_AK_MODE, 6'h09, `SFRD_RT_CFG, `SFRD_DK_NONE, `SFRD_SP_MEM};
      `SFRD_OP_FRD: dc = {`SFRD_AK_MODE, 6'h09, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DOFR: dc = {`SFRD_AK_MODE, 6'h0A, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DIOFR: dc = {`SFRD_AK_MODE, 6'h12, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_QOFR: dc = {`SFRD_AK_MODE, 6'h0C, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_QIOFR: dc = {`SFRD_AK_MODE, 6'h24, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DTR_FRD: dc = {`SFRD_AK_MODE, 6'h09, `SFRD_RT_DTR, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DTR_DOFR: dc = {`SFRD_AK_MODE, 6'h0A, `SFRD_RT_DTR, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DTR_DIOFR: dc = {`SFRD_AK_MODE, 6'h12, `SFRD_RT_DTR, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DTR_QOFR: dc = {`SFRD_AK_MODE, 6'h0C, `SFRD_RT_DTR, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DTR_QIOFR: dc = {`SFRD_AK_MODE, 6'h24, `SFRD_RT_DTR, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_QWORD: dc = {`SFRD_AK_MODE, 6'h24, `SFRD_RT_CFG, `SFRD_DK_FOUR, `SFRD_SP_MEM};
      `SFRD_OP_RD4: dc = {`SFRD_AK_FOUR, 6'h09, `SFRD_RT_CFG, `SFRD_DK_NONE, `SFRD_SP_MEM};
      `SFRD_OP_FRD4: dc = {`SFRD_AK_FOUR, 6'h09, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DOFR4: dc = {`SFRD_AK_FOUR, 6'h0A, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DIOFR4: dc = {`SFRD_AK_FOUR, 6'h12, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_QOFR4: dc = {`SFRD_AK_FOUR, 6'h0C, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_QIOFR4: dc = {`SFRD_AK_FOUR, 6'h24, `SFRD_RT_CFG, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DTR_FRD4: dc = {`SFRD_AK_FOUR, 6'h09, `SFRD_RT_DTR, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DTR_DIOFR4: dc = {`SFRD_AK_FOUR, 6'h12, `SFRD_RT_DTR, `SFRD_DK_CFG, `SFRD_SP_MEM};
      `SFRD_OP_DTR_QIOFR4: dc = {`SFRD_AK_FOUR, 6'h24, `SFRD_RT_DTR, `SFRD_DK_CFG, `SFRD_SP_MEM};
      default: dc = {`SFRD_AK_NONE, 6'h09, `SFRD_RT_CFG, `SFRD_DK_NONE, `SFRD_SP_NONE};
    endcase
  end

  // A zero in the configured count selects the factory default.
  always @* begin
    case (dc_dk)
      `SFRD_DK_NONE: dc_dummy = 6'h00;
      `SFRD_DK_CFG: dc_dummy = {2'h0, (cfg_dummy_cycles == 4'h0) ? `SFRD_DUMMY_FACTORY :
                                        cfg_dummy_cycles};
      `SFRD_DK_EIGHT: dc_dummy = {2'h0, `SFRD_DUMMY_DISC};
      default: dc_dummy = {2'h0, `SFRD_DUMMY_QWORD};
    endcase
  end

  // --------------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= `SFRD_ST_IDLE;
      opc_reg <= 8'h00;
      cnt_reg <= 6'h00;
      addr_reg <= 32'h0000_0000;
      abits_reg <= `SFRD_ABITS3;
      alines_reg <= `SFRD_L1;
      dlines_reg <= `SFRD_L1;
      dtr_reg <= 1'b0;
      qword_reg <= 1'b0;
      dummy_reg <= 6'h00;
      space_reg <= `SFRD_SP_NONE;
      shift_reg <= 8'h00;
      left_reg <= 4'h0;
      go_reg <= 1'b0;
      dq_out_reg <= `SFRD_OE_OFF;
      dq_oe_reg <= `SFRD_OE_OFF;
      active_reg <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (cs_n_s) begin
        state_reg <= `SFRD_ST_IDLE;
        dq_oe_reg <= `SFRD_OE_OFF;
        dq_out_reg <= `SFRD_OE_OFF;
        active_reg <= 1'b0;
      end else begin
        case (state_reg)
          `SFRD_ST_IDLE: begin
            state_reg <= `SFRD_ST_OPC;
            cnt_reg <= 6'h00;
            opc_reg <= 8'h00;
          end
          `SFRD_ST_OPC: begin
            if (op_edge) begin
              opc_reg <= opc_next;
              cnt_reg <= opc_cnt;
              if (opc_cnt == `SFRD_OPC_BITS) begin
                if (!accept) begin
                  state_reg <= `SFRD_ST_IGNORE;
                end else begin
                  space_reg <= dc_sp;
                  alines_reg <= (cfg_protocol == `SFRD_PROTO_EXT) ? dc_al : pl;
                  dlines_reg <= f_max(pl, dc_dl);
                  dtr_reg <= eff_dtr;
                  qword_reg <= dc_qword;
                  abits_reg <= dc_wide ? `SFRD_ABITS4 : `SFRD_ABITS3;
                  dummy_reg <= dc_dummy;
                  addr_reg <= 32'h0000_0000;
                  cnt_reg <= 6'h00;
                  left_reg <= 4'h0;
                  active_reg <= 1'b1;
                  if (dc_sp == `SFRD_SP_ID) begin
                    state_reg <= `SFRD_ST_DATA;
                    go_reg <= 1'b1;
                  end else begin
                    state_reg <= `SFRD_ST_ADDR;
                  end
                end
              end
            end
          end
          `SFRD_ST_ADDR: begin
            if (in_edge) begin
              addr_reg <= addr_next;
              cnt_reg <= addr_cnt;
              if (addr_cnt == abits_reg) begin
                if (qword_reg) begin
                  addr_reg <= {addr_next[31:1], 1'b0};
                end
                go_reg <= 1'b1;
                cnt_reg <= dummy_reg;
                state_reg <= (dummy_reg == 6'h00) ? `SFRD_ST_DATA : `SFRD_ST_DUMMY;
              end
            end
          end
          `SFRD_ST_DUMMY: begin
            if (rise) begin
              cnt_reg <= cnt_reg - 6'h01;
              if (cnt_reg == 6'h01) begin
                state_reg <= `SFRD_ST_DATA;
              end
            end
          end
          `SFRD_ST_DATA: begin
            if (out_edge) begin
              dq_oe_reg <= f_oe(dlines_reg);
              if (left_reg == 4'h0) begin
                dq_out_reg <= f_drive(next_byte, dlines_reg);
                shift_reg <= next_byte << dlines_reg;
                left_reg <= `SFRD_BYTE_BITS - {1'b0, dlines_reg};
              end else begin
                dq_out_reg <= f_drive(shift_reg, dlines_reg);
                shift_reg <= shift_reg << dlines_reg;
                left_reg <= left_reg - {1'b0, dlines_reg};
              end
            end
          end
          `SFRD_ST_IGNORE: begin
            state_reg <= `SFRD_ST_IGNORE;
          end
          default: begin
            state_reg <= `SFRD_ST_IGNORE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Address mode latch, loaded from the nonvolatile setting after reset
  // --------------------------------------------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      init_reg <= 1'b0;
      addr4_reg <= 1'b0;
    end else begin
      init_reg <= 1'b1;
      if (!init_reg) begin
        addr4_reg <= cfg_nv_addr4;
      end else if (addr4_cmd_pulse) begin
        addr4_reg <= addr4_cmd_enter;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Fetch engine: one request in flight, prefetch into the buffer
  // --------------------------------------------------------------------------
  wire req_acc = req_valid_reg & fetch_req_ready;
  wire rsp_acc = fetch_rsp_valid & buf_in_ready;
  wire [31:0] faddr_inc = faddr_reg + `SFRD_ADDR_ONE;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      faddr_reg <= 32'h0000_0000;
      fspace_reg <= `SFRD_SP_NONE;
      fwide_reg <= 1'b0;
      fon_reg <= 1'b0;
      req_valid_reg <= 1'b0;
      inflight_reg <= 1'b0;
      stale_reg <= 1'b0;
    end else begin
      if (req_acc) begin
        inflight_reg <= 1'b1;
      end else if (rsp_acc) begin
        inflight_reg <= 1'b0;
      end
      // A response still owed when select rises belongs to a dead read.
      if (cs_n_s & ((inflight_reg & ~rsp_acc) | req_acc)) begin
        stale_reg <= 1'b1;
      end else if (rsp_acc) begin
        stale_reg <= 1'b0;
      end
      if (cs_n_s) begin
        fon_reg <= 1'b0;
        req_valid_reg <= 1'b0;
      end else if (go_reg) begin
        faddr_reg <= addr_reg;
        fspace_reg <= space_reg;
        fwide_reg <= (abits_reg == `SFRD_ABITS4);
        fon_reg <= 1'b1;
        // Requesting at once leaves a zero-dummy read time to fill the buffer.
        req_valid_reg <= ~inflight_reg & ~stale_reg;
      end else if (req_acc) begin
        req_valid_reg <= 1'b0;
        if (fspace_reg == `SFRD_SP_DISC) begin
          faddr_reg <= faddr_inc & `SFRD_MASK_DISC;
        end else if ((fspace_reg == `SFRD_SP_MEM) & ~fwide_reg) begin
          faddr_reg <= faddr_inc & `SFRD_MASK_MEM24;
        end else begin
          faddr_reg <= faddr_inc;
        end
      end else if (fon_reg & ~req_valid_reg & ~inflight_reg & ~stale_reg & buf_in_ready) begin
        req_valid_reg <= 1'b1;
      end
    end
  end

  sfrd_pair_buffer #(
    .WIDTH(8)
  ) u_buffer (
    .clock(clock),
    .arst_n(arst_n),
    .flush(cs_n_s),
    .in_valid(fetch_rsp_valid & ~stale_reg),
    .in_ready(buf_in_ready),
    .in_data(fetch_rsp_data),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_data)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign serial_data_lines_out = dq_out_reg;
  assign serial_data_lines_oe = dq_oe_reg;
  assign fetch_req_valid = req_valid_reg;
  assign fetch_req_addr = faddr_reg;
  assign fetch_req_space = fspace_reg;
  assign fetch_rsp_ready = buf_in_ready;
  assign addr4_mode = addr4_reg;
  assign cmd_active = active_reg;

endmodule
